/* src/olsr_defs.vh */
// Constants of the overload and speed reference block
// Assumes APB byte addresses and a 100 MHz pclk
`ifndef OLSR_DEFS_VH
`define OLSR_DEFS_VH

// Register byte offsets
`define OLSR_CTRL_OFS      8'h00
`define OLSR_WARN_PCT_OFS  8'h04
`define OLSR_DERATE_OFS    8'h08
`define OLSR_FUNC_OFS      8'h0c
`define OLSR_GAIN_OFS      8'h10
`define OLSR_BASE_OFS      8'h14
`define OLSR_LIMIT_OFS     8'h18
`define OLSR_OFFSET_OFS    8'h1c
`define OLSR_STATUS_OFS    8'h20
`define OLSR_MASK_OFS      8'h24
`define OLSR_STATE_OFS     8'h28
`define OLSR_SPEED_OFS     8'h2c

// Control register bit positions
`define OLSR_CTRL_RESTART  0
`define OLSR_CTRL_INIT     1
`define OLSR_CTRL_WPROT    2

// Status bit positions
`define OLSR_ST_WARN       0
`define OLSR_ST_ALM_LOW    1
`define OLSR_ST_ALM_HIGH   2
`define OLSR_ST_CAL_DONE   3
`define OLSR_ST_CAL_REFUSE 4
`define OLSR_ST_W          5

// Reset values and ranges
`define OLSR_WARN_PCT_RST  7'h14
`define OLSR_WARN_PCT_MIN  7'h01
`define OLSR_WARN_PCT_MAX  7'h64
`define OLSR_DERATE_RST    7'h64
`define OLSR_DERATE_MIN    7'h0a
`define OLSR_DERATE_MAX    7'h64
`define OLSR_FUNC_RST      16'h0000
`define OLSR_METHOD_RST    4'h0
`define OLSR_GAIN_RST      12'h258
`define OLSR_GAIN_MIN      12'h096
`define OLSR_GAIN_MAX      12'hbb8
`define OLSR_BASE_RST      16'h0400
`define OLSR_LIMIT_RST     32'h000f_4240
`define OLSR_MASK_RST      5'h00

// Fixed high-load alarm characteristic
`define OLSR_HIGH_MULT     2'h3
`define OLSR_HIGH_MS       12'h3e8

// Timing: one millisecond, hold and flash in ms
`define OLSR_CLK_MHZ       100
`define OLSR_MS_NS         1000000
`define OLSR_HOLD_MS       12'h3e8
`define OLSR_FLASH_MS      12'h3e8

// Speed command for rated speed
`define OLSR_SPEED_RATED   32'h0000_03e8

// Panel display states
`define OLSR_D_SELECT      2'h0
`define OLSR_D_PROMPT      2'h1
`define OLSR_D_REFUSE      2'h2
`define OLSR_D_DONE        2'h3

`endif

/* src/olsr_div.v */
// Serial unsigned divider, one quotient bit per clock
// Assumes start only while not busy and a non-zero divisor
`timescale 1ns/1ps
`default_nettype none
module olsr_div #(
  parameter W = 32
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // Request
  input  wire         start,
  input  wire [W-1:0] dividend,
  input  wire [15:0]  divisor,
  // Answer
  output wire         busy,
  output reg          done_ff,
  output reg  [W-1:0] quot_ff
);

  reg [W-1:0] num_ff;
  reg [W:0]   rem_ff;
  reg [5:0]   cnt_ff;
  wire [W:0]  trial = {rem_ff[W-1:0], num_ff[W-1]};
  wire        fits  = trial >= {{(W-15){1'b0}}, divisor};

  assign busy = cnt_ff != 6'h00;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      num_ff  <= {W{1'b0}};
      rem_ff  <= {(W+1){1'b0}};
      cnt_ff  <= 6'h00;
      done_ff <= 1'b0;
      quot_ff <= {W{1'b0}};
    end else begin
      done_ff <= 1'b0;
      if (start && !busy) begin
        num_ff <= dividend;
        rem_ff <= {(W+1){1'b0}};
        cnt_ff <= W[5:0];
      end else if (busy) begin
        rem_ff <= fits ? trial - {{(W-15){1'b0}}, divisor} : trial;
        num_ff <= {num_ff[W-2:0], fits};
        cnt_ff <= cnt_ff - 6'h01;
        if (cnt_ff == 6'h01) begin
          done_ff <= 1'b1;
          quot_ff <= {num_ff[W-2:0], fits};
        end
      end
    end
  end

endmodule
`default_nettype wire

/* src/olsr_top.v */
// Overload timing, speed reference scaling and offset calibration
// Assumes an APB master, synchronous inputs and a 100 MHz pclk
//
// Contract
// - Warning at set percent of alarm time
// - Warning percent 1..100, effective immediately
// - Drive warning output on overload warning
// - High-load alarm characteristic fixed, unsettable
// - Accumulate above base current times derating
// - Derating 10..100, default 100, after restart
// - Derating change also shifts warning timing
// - Speed control when method digit zero
// - Speed proportional to reference over gain
// - Calibration stores zero-input offset, corrects reference
// - Offset survives parameter initialisation
// - Write protect: flash refusal, no calibration
// - Set key calibrates, flashes done, reprompts
// - One-second hold enters, another exits
//
// The implementer's own choices: register access over APB and the register offsets.
`include "olsr_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module olsr_top #(
  parameter MS_CYCLES = (`OLSR_MS_NS / 1000) * `OLSR_CLK_MHZ
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Drive signals
  input  wire [15:0] motor_current,
  input  wire [15:0] speed_ref,
  input  wire        servo_enable,
  // Panel keys
  input  wire        key_mode_set,
  input  wire        key_data_shift,
  // Protection outputs
  output reg         warn_n_ff,
  output reg         alarm_low_ff,
  output reg         alarm_high_ff,
  // Speed command
  output reg  [15:0] speed_cmd_ff,
  output reg         speed_fwd_ff,
  output reg         speed_mode_ff,
  // Panel display
  output reg  [1:0]  disp_ff,
  output wire        disp_flash,
  // Interrupt
  output wire        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond enable
  reg  [31:0] ms_cnt_ff;
  wire        ms_tick = ms_cnt_ff == MS_CYCLES - 1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ms_cnt_ff <= 32'h0000_0000;
    else
      ms_cnt_ff <= ms_tick ? 32'h0000_0000 : ms_cnt_ff + 32'h0000_0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire [6:0]  wr_pct = pwdata[6:0];
  wire [11:0] wr_gain = pwdata[11:0];
  wire wr_ctrl = wr_en && paddr == `OLSR_CTRL_OFS;
  wire wr_pct_ok = pwdata[31:7] == 25'h0 && wr_pct >= `OLSR_WARN_PCT_MIN &&
                   wr_pct <= `OLSR_WARN_PCT_MAX;
  wire wr_der_ok = pwdata[31:7] == 25'h0 && wr_pct >= `OLSR_DERATE_MIN &&
                   wr_pct <= `OLSR_DERATE_MAX;
  wire wr_gain_ok = pwdata[31:12] == 20'h0 && wr_gain >= `OLSR_GAIN_MIN &&
                    wr_gain <= `OLSR_GAIN_MAX;
  reg  addr_ok;
  reg  data_bad;

  always @* begin
    addr_ok  = 1'b1;
    data_bad = 1'b0;
    case (paddr)
      `OLSR_CTRL_OFS, `OLSR_FUNC_OFS, `OLSR_BASE_OFS, `OLSR_LIMIT_OFS,
      `OLSR_OFFSET_OFS, `OLSR_STATUS_OFS, `OLSR_MASK_OFS, `OLSR_STATE_OFS,
      `OLSR_SPEED_OFS: data_bad = 1'b0;
      `OLSR_WARN_PCT_OFS: data_bad = pwrite && !wr_pct_ok;
      `OLSR_DERATE_OFS:   data_bad = pwrite && !wr_der_ok;
      `OLSR_GAIN_OFS:     data_bad = pwrite && !wr_gain_ok;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && (!addr_ok || data_bad);

  wire restart  = wr_ctrl && pwdata[`OLSR_CTRL_RESTART];
  wire par_init = wr_ctrl && pwdata[`OLSR_CTRL_INIT];

  ////////////////////////////////////////////////////////////////////////////
  // Parameter registers
  reg [6:0]  warn_pct_ff;
  reg [6:0]  derate_ff;
  reg [6:0]  derate_act_ff;
  reg [15:0] func_ff;
  reg [3:0]  method_act_ff;
  reg [11:0] gain_ff;
  reg [15:0] base_ff;
  reg [31:0] limit_ff;
  reg        wprot_ff;
  reg [4:0]  mask_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_pct_ff   <= `OLSR_WARN_PCT_RST;
      derate_ff     <= `OLSR_DERATE_RST;
      derate_act_ff <= `OLSR_DERATE_RST;
      func_ff       <= `OLSR_FUNC_RST;
      method_act_ff <= `OLSR_METHOD_RST;
      gain_ff       <= `OLSR_GAIN_RST;
      base_ff       <= `OLSR_BASE_RST;
      limit_ff      <= `OLSR_LIMIT_RST;
      wprot_ff      <= 1'b0;
      mask_ff       <= `OLSR_MASK_RST;
    end else if (par_init) begin
      warn_pct_ff <= `OLSR_WARN_PCT_RST;
      derate_ff   <= `OLSR_DERATE_RST;
      func_ff     <= `OLSR_FUNC_RST;
      gain_ff     <= `OLSR_GAIN_RST;
    end else begin
      if (wr_en && paddr == `OLSR_WARN_PCT_OFS && wr_pct_ok)
        warn_pct_ff <= wr_pct;
      if (wr_en && paddr == `OLSR_DERATE_OFS && wr_der_ok)
        derate_ff <= wr_pct;
      if (wr_en && paddr == `OLSR_FUNC_OFS)
        func_ff <= pwdata[15:0];
      if (wr_en && paddr == `OLSR_GAIN_OFS && wr_gain_ok)
        gain_ff <= wr_gain;
      if (wr_en && paddr == `OLSR_BASE_OFS)
        base_ff <= pwdata[15:0];
      if (wr_en && paddr == `OLSR_LIMIT_OFS)
        limit_ff <= pwdata;
      if (wr_en && paddr == `OLSR_MASK_OFS)
        mask_ff <= pwdata[4:0];
      if (wr_ctrl)
        wprot_ff <= pwdata[`OLSR_CTRL_WPROT];
      if (restart) begin
        derate_act_ff <= derate_ff;
        method_act_ff <= func_ff[7:4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overload accumulation
  wire [22:0] cur_x100  = motor_current * 7'h64;
  wire [22:0] base_der  = base_ff * derate_act_ff;
  reg  [31:0] accum_ff;
  reg  [11:0] high_cnt_ff;
  wire        over_base = cur_x100 > base_der;
  wire [31:0] excess = {9'h000, over_base ? cur_x100 - base_der : base_der - cur_x100};
  // Warn at percent of alarm level
  // Same accumulator drives warn and the low-load alarm
  wire [38:0] acc_x100  = accum_ff * 7'h64;
  wire [38:0] lim_x_pct = limit_ff * warn_pct_ff;
  wire        warn_lvl  = acc_x100 >= lim_x_pct;
  wire [17:0] high_thr  = base_ff * `OLSR_HIGH_MULT;
  wire        high_load = {2'b00, motor_current} >= high_thr;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum_ff      <= 32'h0000_0000;
      high_cnt_ff   <= 12'h000;
      warn_n_ff     <= 1'b1;
      alarm_low_ff  <= 1'b0;
      alarm_high_ff <= 1'b0;
    end else begin
      warn_n_ff <= !warn_lvl;
      if (ms_tick) begin
        if (over_base)
          accum_ff <= (accum_ff + excess >= limit_ff) ? limit_ff : accum_ff + excess;
        else
          accum_ff <= (accum_ff > excess) ? accum_ff - excess : 32'h0000_0000;
        if (!high_load)
          high_cnt_ff <= 12'h000;
        else if (high_cnt_ff != `OLSR_HIGH_MS)
          high_cnt_ff <= high_cnt_ff + 12'h001;
      end
      if (restart) begin
        alarm_low_ff  <= 1'b0;
        alarm_high_ff <= 1'b0;
      end else begin
        if (accum_ff >= limit_ff)
          alarm_low_ff <= 1'b1;
        if (high_cnt_ff == `OLSR_HIGH_MS)
          alarm_high_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed reference scaling
  reg  [15:0] offset_ff;
  wire [16:0] corr = {speed_ref[15], speed_ref} - {offset_ff[15], offset_ff};
  wire        neg = corr[16];
  wire [16:0] mag = neg ? 17'h00000 - corr : corr;
  wire [31:0] div_q;
  wire        div_done;
  wire        div_busy;
  reg         neg_ff;

  olsr_div #(
    .W (32)
  ) u_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (!div_busy),
    .dividend (mag * `OLSR_SPEED_RATED),
    .divisor  ({4'h0, gain_ff}),
    .busy     (div_busy),
    .done_ff  (div_done),
    .quot_ff  (div_q)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      neg_ff        <= 1'b0;
      speed_cmd_ff  <= 16'h0000;
      speed_fwd_ff  <= 1'b1;
      speed_mode_ff <= 1'b1;
    end else begin
      if (!div_busy)
        neg_ff <= neg;
      speed_mode_ff <= method_act_ff == 4'h0;
      if (method_act_ff != 4'h0) begin
        speed_cmd_ff <= 16'h0000;
      end else if (div_done) begin
        speed_cmd_ff <= div_q[31:16] != 16'h0 ? 16'hffff : div_q[15:0];
        speed_fwd_ff <= !neg_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Panel utility sequence
  reg [11:0] hold_ms_ff;
  reg        held_ff;
  reg        set_d_ff;
  reg [11:0] flash_ms_ff;
  reg [9:0]  blink_ff;
  wire       hold_evt = key_data_shift && !held_ff && hold_ms_ff == `OLSR_HOLD_MS;
  wire       set_evt = key_mode_set && !set_d_ff;
  wire       flash_end = flash_ms_ff == `OLSR_FLASH_MS;
  reg        cal_done_p;
  reg        cal_refuse_p;

  assign disp_flash = (disp_ff == `OLSR_D_REFUSE || disp_ff == `OLSR_D_DONE) &&
                      blink_ff[9];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ms_ff   <= 12'h000;
      held_ff      <= 1'b0;
      set_d_ff     <= 1'b0;
      flash_ms_ff  <= 12'h000;
      blink_ff     <= 10'h000;
      disp_ff      <= `OLSR_D_SELECT;
      offset_ff    <= 16'h0000;
      cal_done_p   <= 1'b0;
      cal_refuse_p <= 1'b0;
    end else begin
      set_d_ff     <= key_mode_set;
      cal_done_p   <= 1'b0;
      cal_refuse_p <= 1'b0;
      if (!key_data_shift) begin
        hold_ms_ff <= 12'h000;
        held_ff    <= 1'b0;
      end else if (hold_evt) begin
        held_ff <= 1'b1;
      end else if (ms_tick && hold_ms_ff != `OLSR_HOLD_MS) begin
        hold_ms_ff <= hold_ms_ff + 12'h001;
      end
      if (ms_tick)
        blink_ff <= blink_ff + 10'h001;
      if (ms_tick && !flash_end)
        flash_ms_ff <= flash_ms_ff + 12'h001;
      case (disp_ff)
        `OLSR_D_SELECT: begin
          if (hold_evt) begin
            flash_ms_ff <= 12'h000;
            blink_ff    <= 10'h000;
            if (wprot_ff) begin
              disp_ff      <= `OLSR_D_REFUSE;
              cal_refuse_p <= 1'b1;
            end else begin
              disp_ff <= `OLSR_D_PROMPT;
            end
          end
        end
        `OLSR_D_PROMPT: begin
          if (hold_evt) begin
            disp_ff <= `OLSR_D_SELECT;
          end else if (set_evt) begin
            // Relies on servo off, 0 V
            offset_ff   <= speed_ref;
            disp_ff     <= `OLSR_D_DONE;
            flash_ms_ff <= 12'h000;
            blink_ff    <= 10'h000;
            cal_done_p  <= 1'b1;
          end
        end
        `OLSR_D_REFUSE: begin
          if (flash_end)
            disp_ff <= `OLSR_D_SELECT;
        end
        `OLSR_D_DONE: begin
          if (flash_end)
            disp_ff <= `OLSR_D_PROMPT;
        end
        default: disp_ff <= `OLSR_D_SELECT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status
  reg  [4:0] status_ff;
  reg        warn_d_ff;
  reg        alm_low_d_ff;
  reg        alm_high_d_ff;
  wire [4:0] events;
  wire       rd_status = rd_en && paddr == `OLSR_STATUS_OFS;

  assign events[`OLSR_ST_WARN]       = !warn_n_ff && !warn_d_ff;
  assign events[`OLSR_ST_ALM_LOW]    = alarm_low_ff && !alm_low_d_ff;
  assign events[`OLSR_ST_ALM_HIGH]   = alarm_high_ff && !alm_high_d_ff;
  assign events[`OLSR_ST_CAL_DONE]   = cal_done_p;
  assign events[`OLSR_ST_CAL_REFUSE] = cal_refuse_p;
  assign irq = |(status_ff & mask_ff);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff     <= 5'h00;
      warn_d_ff     <= 1'b0;
      alm_low_d_ff  <= 1'b0;
      alm_high_d_ff <= 1'b0;
    end else begin
      warn_d_ff     <= !warn_n_ff;
      alm_low_d_ff  <= alarm_low_ff;
      alm_high_d_ff <= alarm_high_ff;
      // Set wins over read clear
      status_ff <= (rd_status ? 5'h00 : status_ff) | events;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always @* begin
    prdata = 32'h0000_0000;
    case (paddr)
      `OLSR_CTRL_OFS:     prdata = {29'h0, wprot_ff, 2'b00};
      `OLSR_WARN_PCT_OFS: prdata = {25'h0, warn_pct_ff};
      `OLSR_DERATE_OFS:   prdata = {25'h0, derate_ff};
      `OLSR_FUNC_OFS:     prdata = {16'h0, func_ff};
      `OLSR_GAIN_OFS:     prdata = {20'h0, gain_ff};
      `OLSR_BASE_OFS:     prdata = {16'h0, base_ff};
      `OLSR_LIMIT_OFS:    prdata = limit_ff;
      `OLSR_OFFSET_OFS:   prdata = {16'h0, offset_ff};
      `OLSR_STATUS_OFS:   prdata = {27'h0, status_ff};
      `OLSR_MASK_OFS:     prdata = {27'h0, mask_ff};
      `OLSR_STATE_OFS:    prdata = {8'h0, accum_ff[15:0], servo_enable, derate_act_ff};
      `OLSR_SPEED_OFS:    prdata = {8'h0, method_act_ff, 3'h0, speed_fwd_ff,
                                    speed_cmd_ff};
      default:            prdata = 32'h0000_0000;
    endcase
  end

endmodule
`default_nettype wire

/* test/olsr_top_sva.sv */
// Port-level checks of the overload and speed reference block
// Assumes a single pclk domain and an async active-low presetn
`include "olsr_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module olsr_top_sva (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  // Outputs watched
  input wire logic        warn_n_ff,
  input wire logic        alarm_low_ff,
  input wire logic        alarm_high_ff,
  input wire logic [15:0] speed_cmd_ff,
  input wire logic        speed_mode_ff,
  input wire logic [1:0]  disp_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_acc;
  logic rst_wr;
  assign wr_acc = psel && penable && pwrite;
  assign rst_wr = wr_acc && paddr == `OLSR_CTRL_OFS && pwdata[`OLSR_CTRL_RESTART];
  ////////////////////////////////////////////////////////////////////////////
  sequence leave_s(logic [1:0] st);
    disp_ff == st ##1 disp_ff != st;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  warn_range_a: assert property (
    wr_acc && paddr == `OLSR_WARN_PCT_OFS && (pwdata < 32'h1 || pwdata > 32'h64) |-> pslverr)
    else $error("warning percent out of range accepted");
  derate_range_a: assert property (
    wr_acc && paddr == `OLSR_DERATE_OFS && (pwdata < 32'ha || pwdata > 32'h64) |-> pslverr)
    else $error("derating out of range accepted");
  gain_range_a: assert property (
    wr_acc && paddr == `OLSR_GAIN_OFS && (pwdata < 32'h96 || pwdata > 32'hbb8) |-> pslverr)
    else $error("gain out of range accepted");
  low_latch_a: assert property (alarm_low_ff && !rst_wr |=> alarm_low_ff)
    else $error("low-load alarm dropped without restart");
  high_latch_a: assert property (alarm_high_ff && !rst_wr |=> alarm_high_ff)
    else $error("high-load alarm dropped without restart");
  warn_first_a: assert property ($rose(alarm_low_ff) |-> !warn_n_ff)
    else $error("alarm without warning");
  mode_cmd_a: assert property (
    $fell(speed_mode_ff) |-> ##[0:40] speed_cmd_ff == 16'h0)
    else $error("speed command outside speed control");
  refuse_exit_a: assert property (
    leave_s(`OLSR_D_REFUSE) |-> disp_ff == `OLSR_D_SELECT)
    else $error("refusal flash left to wrong display");
  done_exit_a: assert property (
    leave_s(`OLSR_D_DONE) |-> disp_ff == `OLSR_D_PROMPT)
    else $error("done flash left to wrong display");
  select_exit_a: assert property (
    leave_s(`OLSR_D_SELECT) |-> disp_ff inside {`OLSR_D_PROMPT, `OLSR_D_REFUSE})
    else $error("selection left to wrong display");
endmodule
bind olsr_top olsr_top_sva olsr_top_sva_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .warn_n_ff(warn_n_ff),
  .alarm_low_ff(alarm_low_ff), .alarm_high_ff(alarm_high_ff),
  .speed_cmd_ff(speed_cmd_ff), .speed_mode_ff(speed_mode_ff), .disp_ff(disp_ff));
`default_nettype wire

/* test/olsr_host.sv */
// Host controller model feeding the analog speed reference
// Assumes the bench asks for calibration set-up via cal_prep
`timescale 1ns/1ps
`default_nettype none
module olsr_host #(
  // Input-stage offset seen at zero volts
  parameter logic [15:0] DRIFT = 16'h0005
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Bench control
  input  wire logic        cal_prep,
  input  wire logic [15:0] ref_cmd,
  // Drive side
  output var  logic [15:0] speed_ref,
  output var  logic        servo_enable
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_ref    <= DRIFT;
      servo_enable <= 1'b0;
    end else begin
      servo_enable <= !cal_prep;
      speed_ref    <= cal_prep ? DRIFT : ref_cmd + DRIFT;
    end
  end
endmodule
`default_nettype wire

/* test/olsr_top_tb_top.sv */
// Self-checking bench of the overload and speed reference block
// Assumes ms tick shortened to 10 pclk cycles
`include "olsr_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module olsr_top_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, rerr, kset, kshift, cal_prep;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rdv;
  logic [15:0] cur, ref_cmd;
  wire  [31:0] prdata;
  wire  [15:0] cmd, sref;
  wire  [1:0]  disp;
  wire         pready, pslverr, warn_n, alm_lo, alm_hi, fwd, mode, flash, irq, sen;
  int          err_total, n_compared, cyc;
  logic [15:0] rtab [3] = '{16'h0258, 16'hfed4, 16'h0064};
  logic [31:0] gtab [3] = '{32'h258, 32'h258, 32'h12c};
  logic [31:0] ctab [3] = '{32'h3e8, 32'h1f4, 32'h14d};
  olsr_top #(.MS_CYCLES(10)) olsr_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .motor_current(cur), .speed_ref(sref),
    .servo_enable(sen), .key_mode_set(kset), .key_data_shift(kshift), .warn_n_ff(warn_n),
    .alarm_low_ff(alm_lo), .alarm_high_ff(alm_hi), .speed_cmd_ff(cmd), .speed_fwd_ff(fwd),
    .speed_mode_ff(mode), .disp_ff(disp), .disp_flash(flash), .irq(irq));
  olsr_host olsr_host_i (.pclk(pclk), .presetn(presetn), .cal_prep(cal_prep),
    .ref_cmd(ref_cmd), .speed_ref(sref), .servo_enable(sen));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    xfer(a, 1'b1, d);
    chk("pslverr", 32'(rerr), 32'(e));
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk("prdata", rdv, exp);
  endtask
  task hold;
    kshift <= 1'b1;
    waitc(10015);
    kshift <= 1'b0;
  endtask
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      summarize;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
    pwdata = 32'h0; cur = 16'h0; ref_cmd = 16'h0; kset = 1'b0; kshift = 1'b0;
    cal_prep = 1'b0; err_total = 0; n_compared = 0; cyc = 0;
    waitc(2);
    presetn <= 1'b1;
    rd(`OLSR_WARN_PCT_OFS, 32'h14);
    rd(`OLSR_DERATE_OFS, 32'h64);
    rd(`OLSR_FUNC_OFS, 32'h0);
    rd(`OLSR_GAIN_OFS, 32'h258);
    rd(8'h30, 32'h0);
    chk("pslverr", 32'(rerr), 32'h1);
    wr(`OLSR_WARN_PCT_OFS, 32'h0, 1'b1);
    wr(`OLSR_WARN_PCT_OFS, 32'h65, 1'b1);
    wr(`OLSR_DERATE_OFS, 32'h9, 1'b1);
    wr(`OLSR_GAIN_OFS, 32'h95, 1'b1);
    wr(`OLSR_GAIN_OFS, 32'hbb9, 1'b1);
    $display("test reset done");
    wr(`OLSR_BASE_OFS, 32'h10, 1'b0);
    wr(`OLSR_LIMIT_OFS, 32'h3e80, 1'b0);
    wr(`OLSR_MASK_OFS, 32'h2, 1'b0);
    cur <= 16'h20;
    waitc(5);
    chk("warn_n", 32'(warn_n), 32'h1);
    waitc(30);
    chk("warn_n", 32'(warn_n), 32'h0);
    wr(`OLSR_WARN_PCT_OFS, 32'h64, 1'b0);
    waitc(1);
    chk("warn_n", 32'(warn_n), 32'h1);
    waitc(150);
    chk("alarm_low", 32'(alm_lo), 32'h1);
    chk("irq", 32'(irq), 32'h1);
    rd(`OLSR_STATUS_OFS, 32'h3);
    chk("irq", 32'(irq), 32'h0);
    $display("test overload done");
    cur <= 16'h0;
    wr(`OLSR_DERATE_OFS, 32'h32, 1'b0);
    xfer(`OLSR_STATE_OFS, 1'b0, 32'h0);
    chk("derate", 32'(rdv[6:0]), 32'h64);
    chk("servo_enable", 32'(rdv[7]), 32'h1);
    waitc(250);
    wr(`OLSR_CTRL_OFS, 32'h1, 1'b0);
    xfer(`OLSR_STATE_OFS, 1'b0, 32'h0);
    chk("derate", 32'(rdv[6:0]), 32'h32);
    wr(`OLSR_WARN_PCT_OFS, 32'h14, 1'b0);
    cur <= 16'h10;
    waitc(70);
    chk("warn_n", 32'(warn_n), 32'h0);
    chk("alarm_low", 32'(alm_lo), 32'h0);
    cur <= 16'h30;
    waitc(9750);
    chk("alarm_high", 32'(alm_hi), 32'h0);
    waitc(300);
    chk("alarm_high", 32'(alm_hi), 32'h1);
    cur <= 16'h0;
    wr(`OLSR_CTRL_OFS, 32'h1, 1'b0);
    $display("test derate done");
    wr(`OLSR_CTRL_OFS, 32'h4, 1'b0);
    hold;
    chk("disp", 32'(disp), 32'h2);
    chk("flash", 32'(flash), 32'h0);
    xfer(`OLSR_STATUS_OFS, 1'b0, 32'h0);
    chk("status", 32'(rdv[4:3]), 32'h2);
    waitc(6000);
    chk("flash", 32'(flash), 32'h1);
    chk("disp", 32'(disp), 32'h2);
    waitc(4030);
    chk("disp", 32'(disp), 32'h0);
    rd(`OLSR_OFFSET_OFS, 32'h0);
    wr(`OLSR_CTRL_OFS, 32'h0, 1'b0);
    cal_prep <= 1'b1;
    hold;
    chk("disp", 32'(disp), 32'h1);
    kset <= 1'b1;
    waitc(3);
    chk("disp", 32'(disp), 32'h3);
    kset <= 1'b0;
    xfer(`OLSR_STATUS_OFS, 1'b0, 32'h0);
    chk("status", 32'(rdv[4:3]), 32'h1);
    rd(`OLSR_OFFSET_OFS, 32'h5);
    waitc(10030);
    chk("disp", 32'(disp), 32'h1);
    cal_prep <= 1'b0;
    hold;
    chk("disp", 32'(disp), 32'h0);
    wr(`OLSR_WARN_PCT_OFS, 32'h32, 1'b0);
    wr(`OLSR_CTRL_OFS, 32'h2, 1'b0);
    rd(`OLSR_WARN_PCT_OFS, 32'h14);
    rd(`OLSR_OFFSET_OFS, 32'h5);
    $display("test panel done");
    for (int i = 0; i < 3; i++) begin
      wr(`OLSR_GAIN_OFS, gtab[i], 1'b0);
      ref_cmd <= rtab[i];
      waitc(80);
      chk("speed_cmd", 32'(cmd), ctab[i]);
      chk("speed_fwd", 32'(fwd), 32'(!rtab[i][15]));
    end
    wr(`OLSR_FUNC_OFS, 32'h10, 1'b0);
    wr(`OLSR_CTRL_OFS, 32'h1, 1'b0);
    waitc(80);
    chk("speed_mode", 32'(mode), 32'h0);
    chk("speed_cmd", 32'(cmd), 32'h0);
    wr(`OLSR_FUNC_OFS, 32'h0, 1'b0);
    wr(`OLSR_CTRL_OFS, 32'h1, 1'b0);
    waitc(80);
    chk("speed_mode", 32'(mode), 32'h1);
    chk("speed_cmd", 32'(cmd), 32'h14d);
    $display("test speed done");
    summarize;
  end
endmodule
`default_nettype wire
